// ---- src/ufbg_top.sv ----
// Serial port: AHB-Lite register slave, fractional baud generator, 16-deep
// FIFOs, frame transmitter and receiver, IR encoder/decoder, DMA requests.
// Assumes one bus master, word accesses only, and line inputs already
// synchronous to core_clk.
// Functional notes
// R1 - Independent 16x8 transmit and receive FIFOs; the receive FIFO here is 16x12, status bits stored with each character
// R2 - Depth selectable, one-entry holding register mode
// R3 - Trigger levels 1/8,1/4,1/2,3/4,7/8 of depth
// R4 - 5-8 data bits, parity options, 1-2 stops
// R5 - FIFO-level and end-of-transmission interrupt outputs
// R6 - Receive DMA single on data, burst at level
// R7 - Transmit DMA single on space, burst at level
// R8 - Transmit and receive enables, both set at reset
// R9 - Software disables module before reprogramming control
// R10 - Disable finishes the character in progress
// R11 - Start, data LSB first, parity, stop bits
// R12 - Receive only after a valid start pulse
// R13 - Detect overrun, parity, framing errors and break; break is never flagged here with odd parity or stick parity of 1
// R14 - Store each character with its status flags
// R15 - 16-bit integer plus 6-bit fraction divisor
// R16 - Oversample 16, or 8 when high-speed bit set
// R17 - Software rounds fraction as DIVISOR_FRACTION_PART*64+0.5
// R18 - Reference tick at 16x/8x forms bit timing
// R19 - Divisor and line control latched on line write
// R20 - Software writes line control after divisor change
// R21 - IR encoder/decoder, 3/16 or low-power pulse; at 8x oversampling the pulse here is 2/8 of a bit
// R22 - Low-power pulse clock divides by 1 to 256
// R23 - Start checked mid-bit, stop must be high
// R24 - Busy until FIFO empty and stop bits sent
// R25 - Stick parity sends and checks a constant
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "ufbg_regs.svh"
module ufbg_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        serial_receive_line,
    input  wire logic        sir_rx_in,
    output logic             serial_tx_out,
    output logic             sir_tx_out,
    output logic             irq_fifo_level,
    output logic             irq_end_of_tx,
    output logic             dma_rx_single,
    output logic             dma_rx_burst,
    output logic             dma_tx_single,
    output logic             dma_tx_burst
);
    import ufbg_pkg::*;
    // ==========================================================
    // Helpers
    function automatic logic [4:0] level_of(input logic [2:0] sel, input logic fen);
        logic [4:0] l;
        unique case (sel)
            3'h0: l = 5'h02;
            3'h1: l = 5'h04;
            3'h2: l = 5'h08;
            3'h3: l = 5'h0C;
            3'h4: l = 5'h0E;
            default: l = 5'h08;
        endcase
        return fen ? l : 5'h01;
    endfunction
    function automatic logic parity_of(input logic [7:0] d, input logic [1:0] wlen,
                                       input logic eps, input logic sps);
        // Bits above the word length are masked off before folding
        return sps ? ~eps : (eps ~^ (^(d & (8'hFF >> (2'h3 - wlen))))); // [R4] [R25]
    endfunction
    // ==========================================================
    // Registers and bus slave
    logic [9:0]  ctl_reg;
    logic [15:0] ibrd_reg;
    logic [5:0]  fbrd_reg;
    logic [7:0]  lcrh_reg;
    logic [5:0]  ifls_reg;
    logic [7:0]  ilpr_reg;
    logic [29:0] cfg_reg;
    logic        ovr_reg, wr_pend_reg, rd_pend_reg, hit_reg;
    logic [7:0]  addr_reg;
    logic [31:0] rd_val;
    logic        take, wr_data, rd_data, wr_flag;
    assign take = hsel && hready && htrans[1] && (hsize == 3'b010);
    assign wr_data = wr_pend_reg && hit_reg && (addr_reg == `UFBG_OFS_DATA);
    assign rd_data = rd_pend_reg && hit_reg && (addr_reg == `UFBG_OFS_DATA);
    assign wr_flag = wr_pend_reg && hit_reg && (addr_reg == `UFBG_OFS_FLAG);
    // Reads take one wait state so a read right after a write sees it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {wr_pend_reg, rd_pend_reg, hit_reg, addr_reg} <= 11'h000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= 32'h00000000;
        end else begin
            wr_pend_reg <= take && hwrite;
            rd_pend_reg <= take && !hwrite;
            if (take) begin
                addr_reg <= haddr[7:0];
                hit_reg  <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
            end
            // A new read cannot be taken while the previous one waits
            if (take && !hwrite) hreadyout <= 1'b0;
            if (rd_pend_reg) begin
                hreadyout <= 1'b1;
                hrdata    <= rd_val;
            end
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_reg  <= `UFBG_CTL_RST; // [R8]
            ifls_reg <= `UFBG_IFLS_RST;
            {ibrd_reg, fbrd_reg, lcrh_reg} <= 30'h00000000;
            {ilpr_reg, cfg_reg} <= 38'h0000000000;
        end else if (wr_pend_reg && hit_reg) begin
            unique case (addr_reg)
                `UFBG_OFS_IBRD: ibrd_reg <= hwdata[15:0]; // [R15]
                `UFBG_OFS_FBRD: fbrd_reg <= hwdata[5:0];
                `UFBG_OFS_LCRH: begin
                    lcrh_reg <= hwdata[7:0];
                    cfg_reg  <= {hwdata[7:0], ibrd_reg, fbrd_reg}; // [R19]
                end
                `UFBG_OFS_CTL:  ctl_reg  <= hwdata[9:0];
                `UFBG_OFS_IFLS: ifls_reg <= hwdata[5:0];
                `UFBG_OFS_ILPR: ilpr_reg <= hwdata[7:0];
                default: ;
            endcase
        end
    end
    // ==========================================================
    // Latched configuration
    logic        en, siren, sirlp, high_speed_oversample_select, brk_send, pen, eps, stp2, fen, sps;
    logic [1:0]  wlen;
    logic [21:0] div;
    logic [3:0]  os_last, os_half;
    logic [2:0]  nbits_last;
    assign en       = ctl_reg[`UFBG_CTL_EN];
    assign siren    = ctl_reg[`UFBG_CTL_SIREN];
    assign sirlp    = ctl_reg[`UFBG_CTL_SIRLP];
    assign high_speed_oversample_select      = ctl_reg[`UFBG_CTL_HSE];
    assign brk_send = cfg_reg[22 + `UFBG_LC_BRK];
    assign pen      = cfg_reg[22 + `UFBG_LC_PEN];
    assign eps      = cfg_reg[22 + `UFBG_LC_EPS];
    assign stp2     = cfg_reg[22 + `UFBG_LC_STP2];
    assign fen      = cfg_reg[22 + `UFBG_LC_FEN];
    assign wlen     = cfg_reg[23 + `UFBG_LC_WLEN -: 2];
    assign sps      = cfg_reg[22 + `UFBG_LC_SPS];
    assign div      = cfg_reg[21:0];
    assign os_last  = high_speed_oversample_select ? `UFBG_OS8 : `UFBG_OS16; // [R16]
    assign os_half  = high_speed_oversample_select ? 4'h3 : 4'h7; // [R23]
    assign nbits_last = {1'b1, wlen}; // [R4]
    // ==========================================================
    // Fractional baud generator
    logic [22:0] acc_reg, acc_sum;
    logic        tick;
    assign acc_sum = acc_reg + `UFBG_FRAC_STEP;
    // Divisor below 1.0 would tick every cycle; generator holds instead
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= 23'h000000;
            tick    <= 1'b0;
        end else if (div[21:6] == 16'h0000) begin
            acc_reg <= 23'h000000;
            tick    <= 1'b0;
        end else begin
            tick    <= acc_sum >= {1'b0, div}; // [R18]
            acc_reg <= (acc_sum >= {1'b0, div}) ? acc_sum - {1'b0, div} : acc_sum; // [R15]
        end
    end
    // Low-power IR pulse clock
    logic [7:0] lp_cnt_reg;
    logic       lp_tick;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lp_cnt_reg <= 8'h00;
            lp_tick    <= 1'b0;
        end else begin
            lp_tick    <= lp_cnt_reg == 8'h00;
            lp_cnt_reg <= (lp_cnt_reg == 8'h00) ? ilpr_reg - 8'h01 : lp_cnt_reg - 8'h01; // [R22]
        end
    end
    // ==========================================================
    // FIFOs
    logic [7:0]  tx_mem [0:15];
    ufbg_rxent_t rx_mem [0:15];
    logic [3:0]  tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
    logic [4:0]  tx_cnt_reg, rx_cnt_reg, depth, tx_lvl, rx_lvl;
    logic        tx_full, rx_full, tx_empty, rx_empty, tx_pop, rx_push;
    ufbg_rxent_t rx_word;
    assign depth    = fen ? `UFBG_FIFO_DEPTH : 5'h01; // [R2]
    assign tx_full  = tx_cnt_reg >= depth;
    assign rx_full  = rx_cnt_reg >= depth;
    assign tx_empty = tx_cnt_reg == 5'h00;
    assign rx_empty = rx_cnt_reg == 5'h00;
    assign tx_lvl   = level_of(ifls_reg[2:0], fen); // [R3]
    assign rx_lvl   = level_of(ifls_reg[5:3], fen);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {tx_wp_reg, tx_rp_reg, tx_cnt_reg} <= 13'h0000;
        end else begin
            if (wr_data && !tx_full) begin
                tx_mem[tx_wp_reg] <= hwdata[7:0]; // [R1]
                tx_wp_reg <= tx_wp_reg + 4'h1;
            end
            if (tx_pop) tx_rp_reg <= tx_rp_reg + 4'h1;
            tx_cnt_reg <= tx_cnt_reg + {4'h0, wr_data && !tx_full} - {4'h0, tx_pop};
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {rx_wp_reg, rx_rp_reg, rx_cnt_reg} <= 13'h0000;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp_reg] <= rx_word; // [R1] [R14]
                rx_wp_reg <= rx_wp_reg + 4'h1;
            end
            if (rd_data && !rx_empty) rx_rp_reg <= rx_rp_reg + 4'h1;
            rx_cnt_reg <= rx_cnt_reg + {4'h0, rx_push} - {4'h0, rd_data && !rx_empty};
        end
    end
    // ==========================================================
    // Transmitter
    ufbg_tx_e   tx_st_reg;
    logic [7:0] tx_sh_reg;
    logic [3:0] tx_os_reg;
    logic [2:0] tx_bit_reg;
    logic [1:0] tx_lp_reg;
    logic       tx_line, tx_bit_end, busy;
    assign tx_bit_end = tick && (tx_os_reg == os_last);
    assign tx_pop = (tx_st_reg == TX_IDLE) && !tx_empty && en &&
                    ctl_reg[`UFBG_CTL_TXE]; // [R8] [R10]
    assign busy = !tx_empty || (tx_st_reg != TX_IDLE); // [R24]
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_st_reg  <= TX_IDLE;
            tx_line    <= 1'b1;
            {tx_sh_reg, tx_os_reg, tx_bit_reg, tx_lp_reg} <= 17'h00000;
        end else begin
            if (tick) tx_os_reg <= tx_bit_end ? 4'h0 : tx_os_reg + 4'h1;
            if (tx_bit_end || tx_pop) begin
                tx_lp_reg <= 2'h0;
            end else if (lp_tick && tx_lp_reg != `UFBG_SIR_LP_W) begin
                tx_lp_reg <= tx_lp_reg + 2'h1;
            end
            unique case (tx_st_reg)
                TX_IDLE: begin
                    tx_line <= 1'b1;
                    if (tx_pop) begin
                        tx_sh_reg <= tx_mem[tx_rp_reg]; // [R11]
                        tx_st_reg <= TX_START;
                        tx_os_reg <= 4'h0;
                        tx_line   <= 1'b0;
                    end
                end
                TX_START: if (tx_bit_end) begin
                    tx_st_reg  <= TX_DATA;
                    tx_bit_reg <= 3'h0;
                    tx_line    <= tx_sh_reg[0]; // [R11]
                end
                TX_DATA: if (tx_bit_end) begin
                    if (tx_bit_reg == nbits_last) begin
                        tx_st_reg  <= pen ? TX_PAR : TX_STOP;
                        tx_line    <= pen ? parity_of(tx_sh_reg, wlen, eps, sps) : 1'b1;
                        tx_bit_reg <= 3'h0;
                    end else begin
                        tx_bit_reg <= tx_bit_reg + 3'h1;
                        tx_line    <= tx_sh_reg[tx_bit_reg + 3'h1];
                    end
                end
                TX_PAR: if (tx_bit_end) begin
                    tx_st_reg  <= TX_STOP;
                    tx_line    <= 1'b1;
                end
                TX_STOP: if (tx_bit_end) begin
                    if (stp2 && tx_bit_reg == 3'h0) begin
                        tx_bit_reg <= 3'h1; // [R4]
                    end else begin
                        tx_st_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end
    // Pins: break forces the line low; IR sends a pulse per zero bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serial_tx_out <= 1'b1;
            sir_tx_out    <= 1'b0;
        end else begin
            serial_tx_out <= siren ? 1'b1 : (tx_line && !brk_send);
            if (!siren || (tx_line && !brk_send)) begin
                sir_tx_out <= 1'b0;
            end else if (sirlp) begin
                sir_tx_out <= tx_lp_reg != `UFBG_SIR_LP_W; // [R21] [R22]
            end else begin
                sir_tx_out <= tx_os_reg < (high_speed_oversample_select ? `UFBG_SIR_W8 : `UFBG_SIR_W16); // [R21]
            end
        end
    end
    // ==========================================================
    // Receiver
    ufbg_rx_e   rx_st_reg;
    logic [7:0] rx_sh_reg;
    logic [3:0] rx_os_reg;
    logic [2:0] rx_bit_reg;
    logic [3:0] sir_hold_reg;
    logic       rx_pe_reg, rxd, rx_smp, stop_err;
    // IR pulses are stretched to a bit time so the frame logic sees levels
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sir_hold_reg <= 4'h0;
        end else if (!sir_rx_in) begin
            sir_hold_reg <= os_last; // [R21]
        end else if (tick && sir_hold_reg != 4'h0) begin
            sir_hold_reg <= sir_hold_reg - 4'h1;
        end
    end
    assign rxd = siren ? (sir_hold_reg == 4'h0) && sir_rx_in : serial_receive_line;
    assign rx_smp = tick && (rx_os_reg == os_last);
    assign stop_err = !rxd;
    // Break: every bit low including parity and stop, flagged only with no parity, even parity or stick parity 0
    assign rx_word = {ovr_reg, (rx_sh_reg == 8'h00) && !rx_pe_reg && stop_err && (!pen ||
                      rx_pe_reg == parity_of(8'h00, wlen, eps, sps)), rx_pe_reg, stop_err,
                      rx_sh_reg};
    assign rx_push = (rx_st_reg == RX_STOP) && rx_smp && !rx_full;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_st_reg  <= RX_IDLE;
            {rx_sh_reg, rx_os_reg, rx_bit_reg, rx_pe_reg} <= 16'h0000;
        end else begin
            if (tick) rx_os_reg <= (rx_os_reg == os_last) ? 4'h0 : rx_os_reg + 4'h1;
            unique case (rx_st_reg)
                RX_IDLE: if (!rxd && en && ctl_reg[`UFBG_CTL_RXE]) begin
                    rx_st_reg <= RX_START; // [R8] [R10]
                    rx_os_reg <= 4'h0;
                end
                RX_START: if (tick && rx_os_reg == os_half) begin
                    {rx_sh_reg, rx_os_reg, rx_bit_reg, rx_pe_reg} <= 16'h0000;
                    rx_st_reg <= rxd ? RX_IDLE : RX_DATA; // [R12] [R23]
                end
                RX_DATA: if (rx_smp) begin
                    rx_sh_reg[rx_bit_reg] <= rxd; // [R23]
                    rx_bit_reg <= rx_bit_reg + 3'h1;
                    if (rx_bit_reg == nbits_last) rx_st_reg <= pen ? RX_PAR : RX_STOP;
                end
                RX_PAR: if (rx_smp) begin
                    rx_pe_reg <= rxd != parity_of(rx_sh_reg, wlen, eps, sps); // [R13] [R25]
                    rx_st_reg <= RX_STOP;
                end
                RX_STOP: if (rx_smp) begin
                    rx_st_reg <= RX_IDLE; // [R23]
                end
            endcase
        end
    end
    // Overrun: held until the next character is stored or software clears it; a new overrun wins over a software clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ovr_reg <= 1'b0;
        end else if ((rx_st_reg == RX_STOP) && rx_smp && rx_full) begin
            ovr_reg <= 1'b1; // [R13]
        end else if (rx_push || wr_flag) begin
            ovr_reg <= 1'b0;
        end
    end
    // ==========================================================
    // Read mux and event outputs
    always_comb begin
        rd_val = 32'h00000000;
        if (hit_reg) begin
            unique case (addr_reg)
                `UFBG_OFS_DATA: rd_val = rx_empty ? 32'h00000000 : {20'h00000, rx_mem[rx_rp_reg]};
                `UFBG_OFS_FLAG: rd_val = {23'h000000, ovr_reg, tx_empty, rx_full, tx_full,
                                          rx_empty, busy, 3'h0};
                `UFBG_OFS_IBRD: rd_val = {16'h0000, ibrd_reg};
                `UFBG_OFS_FBRD: rd_val = {26'h0000000, fbrd_reg};
                `UFBG_OFS_LCRH: rd_val = {24'h000000, lcrh_reg};
                `UFBG_OFS_CTL:  rd_val = {22'h000000, ctl_reg};
                `UFBG_OFS_IFLS: rd_val = {26'h0000000, ifls_reg};
                `UFBG_OFS_ILPR: rd_val = {24'h000000, ilpr_reg};
                default: rd_val = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {irq_fifo_level, irq_end_of_tx, dma_rx_single} <= 3'h0;
            {dma_rx_burst, dma_tx_single, dma_tx_burst} <= 3'h0;
        end else begin
            irq_fifo_level <= (rx_cnt_reg >= rx_lvl) || (tx_cnt_reg <= tx_lvl); // [R5]
            irq_end_of_tx  <= !busy; // [R5]
            dma_rx_single  <= !rx_empty; // [R6]
            dma_rx_burst   <= rx_cnt_reg >= rx_lvl;
            dma_tx_single  <= !tx_full; // [R7]
            dma_tx_burst   <= tx_cnt_reg <= tx_lvl;
        end
    end
endmodule

// ---- src/ufbg_regs.svh ----
// Register map, field positions, reset values and counts of the serial port.
// Included by the package users; definitions only.
`ifndef UFBG_REGS_SVH
`define UFBG_REGS_SVH
`define UFBG_OFS_DATA      8'h00
`define UFBG_OFS_FLAG      8'h04
`define UFBG_OFS_IBRD      8'h08
`define UFBG_OFS_FBRD      8'h0C
`define UFBG_OFS_LCRH      8'h10
`define UFBG_OFS_CTL       8'h14
`define UFBG_OFS_IFLS      8'h18
`define UFBG_OFS_ILPR      8'h1C
`define UFBG_CTL_EN        0
`define UFBG_CTL_SIREN     1
`define UFBG_CTL_SIRLP     2
`define UFBG_CTL_HSE       5
`define UFBG_CTL_TXE       8
`define UFBG_CTL_RXE       9
`define UFBG_CTL_RST       10'h300
`define UFBG_LC_BRK        0
`define UFBG_LC_PEN        1
`define UFBG_LC_EPS        2
`define UFBG_LC_STP2       3
`define UFBG_LC_FEN        4
`define UFBG_LC_WLEN       5
`define UFBG_LC_SPS        7
`define UFBG_FL_BUSY       3
`define UFBG_FL_RXFE       4
`define UFBG_FL_TXFF       5
`define UFBG_FL_RXFF       6
`define UFBG_FL_TXFE       7
`define UFBG_FL_OVR        8
`define UFBG_ST_FE         8
`define UFBG_ST_PE         9
`define UFBG_ST_BE         10
`define UFBG_ST_OE         11
`define UFBG_IFLS_RST      6'h12
`define UFBG_FIFO_DEPTH    5'h10
`define UFBG_FRAC_STEP     23'h000040
`define UFBG_OS16          4'hF
`define UFBG_OS8           4'h7
`define UFBG_SIR_W16       4'h3
`define UFBG_SIR_W8        4'h2
`define UFBG_SIR_LP_W      2'h3
`endif

// ---- src/ufbg_pkg.sv ----
// Types shared by the serial port design.
// Assumes nothing beyond a SystemVerilog compiler.
package ufbg_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufbg_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufbg_rx_e;
    typedef logic [11:0] ufbg_rxent_t;
endpackage

// ---- verification/ufbg_asserts.sv ----
// Checker for the serial port top: bus wait states, DMA and interrupt levels.
// Assumes one clock domain and hready tied to hreadyout.
`timescale 1ns/100ps
module ufbg_asserts (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic [2:0] hsize,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       serial_tx_out,
    input wire logic       irq_fifo_level,
    input wire logic       irq_end_of_tx,
    input wire logic       dma_rx_single,
    input wire logic       dma_rx_burst,
    input wire logic       dma_tx_single,
    input wire logic       dma_tx_burst
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Bus phases
    sequence rd_taken;
        hsel && hready && htrans[1] && !hwrite && hsize == 3'b010;
    endsequence
    sequence wr_taken;
        hsel && hready && htrans[1] && hwrite && hsize == 3'b010;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_one_wait: assert property (rd_taken |=> one_wait)
        else $error("read did not take exactly one wait state");
    a_write_no_wait: assert property (wr_taken |=> hreadyout)
        else $error("write data phase stalled");
    // ==========================================
    // Levels and line
    a_rx_burst_single: assert property (dma_rx_burst |-> dma_rx_single)
        else $error("receive burst without receive single");
    a_irq_level_sum: assert property (irq_fifo_level == (dma_rx_burst || dma_tx_burst))
        else $error("fifo level interrupt disagrees with burst levels");
    a_eot_tx_space: assert property (irq_end_of_tx |-> dma_tx_single && dma_tx_burst)
        else $error("idle transmitter without free transmit space");
    a_eot_line_high: assert property (irq_end_of_tx |-> serial_tx_out)
        else $error("line low while transmitter reported idle");
    // Shortest legal bit is 8 cycles: divisor 1.0 with 8x oversampling
    a_start_bit_hold: assert property ($fell(serial_tx_out) |-> !serial_tx_out[*8])
        else $error("low bit shorter than one bit period");
    a_busy_on_start: assert property ($fell(serial_tx_out) |=> !irq_end_of_tx)
        else $error("transmitter idle during a frame");
endmodule
bind ufbg_top ufbg_asserts i_asserts (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
    .serial_tx_out(serial_tx_out), .irq_fifo_level(irq_fifo_level),
    .irq_end_of_tx(irq_end_of_tx), .dma_rx_single(dma_rx_single),
    .dma_rx_burst(dma_rx_burst), .dma_tx_single(dma_tx_single), .dma_tx_burst(dma_tx_burst));

// ---- verification/ufbg_peer.sv ----
// Remote serial peer: sends and decodes frames of 8 data bits, no parity.
// Assumes the port is set to the same bit period in core_clk cycles.
`timescale 1ns/100ps
module ufbg_peer #(
    parameter int BIT_CYC = 32
) (
    input  wire logic core_clk,
    input  wire logic serial_tx_out,
    output logic      serial_receive_line
);
    int         rx_q[$];
    logic [7:0] sh;
    initial serial_receive_line = 1'b1;
    // A low stop bit lets the bench provoke a framing fault
    task automatic send(input logic [7:0] d, input logic stop_ok);
        logic [10:0] fr;
        // Trailing idle bit: line is released high before the next call drives it
        fr = {1'b1, stop_ok, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            serial_receive_line <= fr[i];
            repeat (BIT_CYC) @(posedge core_clk);
        end
    endtask
    // Mid-bit sampling; a frame with a low stop bit is discarded
    always begin
        @(negedge serial_tx_out);
        repeat (BIT_CYC / 2) @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge core_clk);
            if (i < 8) sh[i] = serial_tx_out;
        end
        if (serial_tx_out === 1'b1) rx_q.push_back(sh);
    end
endmodule

// ---- verification/test_uart_frame_and_baud_generator.sv ----
// Self-checking bench: register bus master, queue model, remote peer.
// Assumes divisor 2.0 at 16x oversampling, so one bit is 32 cycles.
`timescale 1ns/100ps
`include "ufbg_regs.svh"
module test_uart_frame_and_baud_generator;
    logic        core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, sir_rx_in;
    logic        serial_receive_line, serial_tx_out, sir_tx_out, irq_fifo_level, irq_end_of_tx;
    logic        dma_rx_single, dma_rx_burst, dma_tx_single, dma_tx_burst;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  b;
    int          bad_count, samples_checked, cyc, exp_q[$];
    assign hready = hreadyout;
    ufbg_top i_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .serial_receive_line(serial_receive_line), .sir_rx_in(sir_rx_in),
        .serial_tx_out(serial_tx_out), .sir_tx_out(sir_tx_out),
        .irq_fifo_level(irq_fifo_level), .irq_end_of_tx(irq_end_of_tx),
        .dma_rx_single(dma_rx_single), .dma_rx_burst(dma_rx_burst),
        .dma_tx_single(dma_tx_single), .dma_tx_burst(dma_tx_burst));
    ufbg_peer #(.BIT_CYC(32)) i_peer (.core_clk(core_clk), .serial_tx_out(serial_tx_out),
        .serial_receive_line(serial_receive_line));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // ==========================================
    // Single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A hang ends in the closing report
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        {rst, sir_rx_in, hsize} = 5'h1A;
        {hsel, htrans, hwrite, haddr, hwdata} = 68'h0;
        void'($urandom(15));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        bus(0, `UFBG_OFS_CTL, 0);
        check("ctl_reset", rd, 32'h300);
        bus(0, `UFBG_OFS_IFLS, 0);
        check("ifls_reset", rd, 32'h12);
        bus(0, `UFBG_OFS_FLAG, 0);
        check("flag_reset", rd, 32'h90);
        check("idle_pins", {hresp, sir_tx_out, dma_tx_single, dma_tx_burst}, 3);
        bus(0, 8'h40, 0);
        check("unmapped", rd, 0);
        bus(1, `UFBG_OFS_IBRD, 2);
        bus(1, `UFBG_OFS_LCRH, 32'h70);
        bus(1, `UFBG_OFS_CTL, 32'h301);
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            b = $urandom;
            exp_q.push_back(b);
            bus(1, `UFBG_OFS_DATA, {24'h0, b});
        end
        bus(0, `UFBG_OFS_FLAG, 0);
        check("busy", rd[`UFBG_FL_BUSY], 1);
        for (int i = 0; i < 600 && rd[`UFBG_FL_BUSY]; i++) bus(0, `UFBG_OFS_FLAG, 0);
        check("eot", irq_end_of_tx, 1);
        check("tx_count", i_peer.rx_q.size(), exp_q.size());
        while (exp_q.size() && i_peer.rx_q.size()) begin
            check("tx_char", i_peer.rx_q.pop_front(), exp_q.pop_front());
        end
        $display("transmit done");
        for (int i = 0; i < 8; i++) begin
            b = $urandom;
            exp_q.push_back(b);
            i_peer.send(b, 1'b1);
        end
        repeat (4) @(posedge core_clk);
        check("rx_burst", {dma_rx_burst, irq_fifo_level}, 3);
        while (exp_q.size()) begin
            bus(0, `UFBG_OFS_DATA, 0);
            check("rx_char", rd, exp_q.pop_front());
        end
        repeat (2) @(posedge core_clk);
        check("rx_single", dma_rx_single, 0);
        i_peer.send(8'hA5, 1'b0);
        repeat (4) @(posedge core_clk);
        bus(0, `UFBG_OFS_DATA, 0);
        check("frame_err", rd, 32'h1A5);
        $display("receive done");
        test_done();
    end
endmodule
